// ===== logic/mmrb_regs.svh
// Register window offsets, field positions and reset values.
// Assumes the core decodes nothing itself; the block compares the high
// address byte against the user-assigned window base.
`ifndef MMRB_REGS_SVH
`define MMRB_REGS_SVH
`define MMRB_OFF_A_IN 8'h00
`define MMRB_OFF_B_IN 8'h01
`define MMRB_OFF_A_MODE 8'h02
`define MMRB_OFF_B_MODE 8'h03
`define MMRB_OFF_A_OUT 8'h04
`define MMRB_OFF_B_OUT 8'h05
`define MMRB_OFF_A_DIR 8'h06
`define MMRB_OFF_B_DIR 8'h07
`define MMRB_OFF_A_DRV 8'h08
`define MMRB_OFF_B_DRV 8'h09
`define MMRB_OFF_A_ICELL 8'h0a
`define MMRB_OFF_B_ICELL 8'h0b
`define MMRB_OFF_A_OE 8'h0c
`define MMRB_OFF_B_OE 8'h0d
`define MMRB_OFF_C_IN 8'h10
`define MMRB_OFF_D_IN 8'h11
`define MMRB_OFF_C_OUT 8'h12
`define MMRB_OFF_D_OUT 8'h13
`define MMRB_OFF_C_DIR 8'h14
`define MMRB_OFF_D_DIR 8'h15
`define MMRB_OFF_C_DRV 8'h16
`define MMRB_OFF_D_DRV 8'h17
`define MMRB_OFF_C_ICELL 8'h18
`define MMRB_OFF_C_OE 8'h1a
`define MMRB_OFF_D_OE 8'h1b
`define MMRB_OFF_CELL_AB 8'h20
`define MMRB_OFF_CELL_BC 8'h21
`define MMRB_OFF_MASK_AB 8'h22
`define MMRB_OFF_MASK_BC 8'h23
`define MMRB_OFF_PWR0 8'hb0
`define MMRB_OFF_PWR2 8'hb4
`define MMRB_OFF_PRI_LOCK 8'hc0
`define MMRB_OFF_SEC_LOCK 8'hc2
`define MMRB_OFF_PAGE 8'he0
`define MMRB_OFF_PLACE 8'he2
`define MMRB_RST_BYTE 8'h00
`define MMRB_SEC_LOCK_SECURE_BIT 7
`define MMRB_PLACE_SRAM_PROG 0
`define MMRB_PLACE_SEC_PROG 1
`define MMRB_PLACE_PRI_PROG 2
`define MMRB_PLACE_SEC_DATA 3
`define MMRB_PLACE_PRI_DATA 4
`define MMRB_RDY_PORT 2
`define MMRB_RDY_BIT 3
`endif

// ===== logic/mmrb_pkg.sv
// Types shared by the memory module register bank.
// Assumes offsets and field positions come from mmrb_regs.svh.
package mmrb_pkg;
  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_BUSY = 2'b01,
    FL_SUSP = 2'b11
  } mmrb_fl_state_t;
  typedef enum logic [1:0] {
    BLK_PRIMARY = 2'b00,
    BLK_SECONDARY = 2'b01,
    BLK_LOGIC = 2'b10,
    BLK_CONFIG = 2'b11
  } mmrb_block_t;
  typedef enum logic [1:0] {
    PATH_CORE = 2'b00,
    PATH_SCAN = 2'b01,
    PATH_PROGRAMMER = 2'b10
  } mmrb_path_t;
  typedef struct packed {
    logic start;
    logic erase;
    mmrb_block_t target;
    logic [1:0] sector;
    mmrb_path_t path;
    logic suspend;
    logic resume;
  } mmrb_flash_req_t;
  typedef struct packed {
    logic [3:0] primary;
    logic [1:0] secondary;
    logic sram;
  } mmrb_mem_sel_t;
endpackage

// ===== logic/mmrb_top.sv
// Memory module register bank: register window, port pin control,
// output cells, memory selects and flash program/erase sequencer.
// Assumes all inputs are synchronous to i_ref_clk and that the core
// strobes i_rd/i_wr for one cycle per access.
`timescale 1ns/1ns
`include "mmrb_regs.svh"
module mmrb_top #(
  parameter int PROGRAM_CYCLES = 16,
  parameter int ERASE_CYCLES = 64
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_window_base,
  input wire logic [15:0] i_addr,
  input wire logic i_ale,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [3:0][7:0] i_pin_in,
  input wire logic [2:0][7:0] i_input_cells,
  input wire logic [3:0] i_primary_lock,
  input wire logic [1:0] i_secondary_lock,
  input wire logic i_security,
  input wire logic i_rdy_busy_en,
  input wire logic i_psen,
  input wire mmrb_pkg::mmrb_mem_sel_t i_decode_sel,
  input wire mmrb_pkg::mmrb_flash_req_t i_flash_req,
  output logic [7:0] o_rdata,
  output logic [3:0][7:0] o_pin_out,
  output logic [3:0][7:0] o_pin_oe,
  output logic [3:0][7:0] o_drive_type,
  output logic [15:0] o_output_cells,
  output logic [7:0] o_power_0,
  output logic [7:0] o_power_2,
  output logic [7:0] o_page,
  output mmrb_pkg::mmrb_mem_sel_t o_mem_sel,
  output logic o_busy,
  output logic o_erase_suspended,
  output logic o_refused
);
  localparam logic [15:0] PROG_CNT = 16'(PROGRAM_CYCLES);
  localparam logic [15:0] ERASE_CNT = 16'(ERASE_CYCLES);

  logic in_win;
  logic [7:0] offset;
  logic wr_hit;
  logic [1:0][7:0] mode;
  logic [3:0][7:0] out_val;
  logic [3:0][7:0] dir;
  logic [7:0] mask_ab;
  logic [7:0] mask_bc;
  logic [7:0] place;
  logic [15:0] addr_latch;
  logic [3:0][7:0] next_out;
  logic [3:0][7:0] next_oe;
  logic [7:0] next_rdata;
  mmrb_pkg::mmrb_fl_state_t state;
  mmrb_pkg::mmrb_fl_state_t next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic erasing;
  logic accept;
  logic next_refused;
  logic flash_target;
  logic locked;

  // window compare on the high address byte
  assign in_win = i_addr[15:8] == i_window_base;
  assign offset = i_addr[7:0];
  assign wr_hit = i_wr && in_win;

  // address latched on ALE for address-out pins
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      addr_latch <= 16'h0000;
    else if (i_ale)
      addr_latch <= i_addr;
  end

  // Port configuration registers; write decode ignores unassigned offsets
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mode <= '0;
      out_val <= '0;
      dir <= '0;
      o_drive_type <= '0;
    end
    else if (wr_hit)
    begin
      // only writable offsets take the data
      case (offset)
        `MMRB_OFF_A_MODE: mode[0] <= i_wdata;
        `MMRB_OFF_B_MODE: mode[1] <= i_wdata;
        `MMRB_OFF_A_OUT: out_val[0] <= i_wdata;
        `MMRB_OFF_B_OUT: out_val[1] <= i_wdata;
        `MMRB_OFF_C_OUT: out_val[2] <= i_wdata;
        `MMRB_OFF_D_OUT: out_val[3] <= i_wdata;
        `MMRB_OFF_A_DIR: dir[0] <= i_wdata;
        `MMRB_OFF_B_DIR: dir[1] <= i_wdata;
        `MMRB_OFF_C_DIR: dir[2] <= i_wdata;
        `MMRB_OFF_D_DIR: dir[3] <= i_wdata;
        `MMRB_OFF_A_DRV: o_drive_type[0] <= i_wdata;
        `MMRB_OFF_B_DRV: o_drive_type[1] <= i_wdata;
        `MMRB_OFF_C_DRV: o_drive_type[2] <= i_wdata;
        `MMRB_OFF_D_DRV: o_drive_type[3] <= i_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_power_0 <= `MMRB_RST_BYTE;
      o_power_2 <= `MMRB_RST_BYTE;
      o_page <= `MMRB_RST_BYTE;
      place <= `MMRB_RST_BYTE;
      mask_ab <= `MMRB_RST_BYTE;
      mask_bc <= `MMRB_RST_BYTE;
    end
    else if (wr_hit)
    begin
      case (offset)
        `MMRB_OFF_PWR0: o_power_0 <= i_wdata;
        `MMRB_OFF_PWR2: o_power_2 <= i_wdata;
        `MMRB_OFF_PAGE: o_page <= i_wdata;
        `MMRB_OFF_PLACE: place <= i_wdata;
        `MMRB_OFF_MASK_AB: mask_ab <= i_wdata;
        `MMRB_OFF_MASK_BC: mask_bc <= i_wdata;
        default: ;
      endcase
    end
  end

  // core writes load the output cells, except bits set in the matching mask, which keep their value
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_output_cells <= 16'h0000;
    else if (wr_hit && offset == `MMRB_OFF_CELL_AB)
      o_output_cells[7:0] <= (o_output_cells[7:0] & mask_ab)
        | (i_wdata & ~mask_ab);
    else if (wr_hit && offset == `MMRB_OFF_CELL_BC)
      o_output_cells[15:8] <= (o_output_cells[15:8] & mask_bc)
        | (i_wdata & ~mask_bc);
  end

  // Pin drivers are computed ahead so that every pad output is a flop
  for (genvar p = 0; p < 4; p++)
  begin : g_port
    for (genvar b = 0; b < 8; b++)
    begin : g_pin
      always_comb
      begin
        next_out[p][b] = out_val[p][b];
        // direction bit high makes the pin an output
        // open-drain drive releases the pin for a high level
        next_oe[p][b] = dir[p][b]
          && !(o_drive_type[p][b] && out_val[p][b]);
        // address-out mode overrides core I/O on ports A and B
        if (p < 2 && mode[p % 2][b])
        begin
          next_out[p][b] = addr_latch[(p % 2) * 8 + b];
          next_oe[p][b] = 1'b1;
        end
        // status pin takes ready/busy when configured
        if (p == `MMRB_RDY_PORT && b == `MMRB_RDY_BIT && i_rdy_busy_en)
        begin
          next_out[p][b] = next_state != mmrb_pkg::FL_BUSY;
          next_oe[p][b] = 1'b1;
        end
      end
    end
  end

  // output value reaches the pins in output mode
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pin_out <= '0;
      o_pin_oe <= '0;
    end
    else
    begin
      o_pin_out <= next_out;
      o_pin_oe <= next_oe;
    end
  end

  // Read mux; unassigned offsets return zero
  always_comb
  begin
    next_rdata = `MMRB_RST_BYTE;
    case (offset)
      `MMRB_OFF_A_IN: next_rdata = i_pin_in[0];
      `MMRB_OFF_B_IN: next_rdata = i_pin_in[1];
      `MMRB_OFF_C_IN: next_rdata = i_pin_in[2];
      `MMRB_OFF_D_IN: next_rdata = i_pin_in[3];
      `MMRB_OFF_A_MODE: next_rdata = mode[0];
      `MMRB_OFF_B_MODE: next_rdata = mode[1];
      `MMRB_OFF_A_OUT: next_rdata = out_val[0];
      `MMRB_OFF_B_OUT: next_rdata = out_val[1];
      `MMRB_OFF_C_OUT: next_rdata = out_val[2];
      `MMRB_OFF_D_OUT: next_rdata = out_val[3];
      `MMRB_OFF_A_DIR: next_rdata = dir[0];
      `MMRB_OFF_B_DIR: next_rdata = dir[1];
      `MMRB_OFF_C_DIR: next_rdata = dir[2];
      `MMRB_OFF_D_DIR: next_rdata = dir[3];
      `MMRB_OFF_A_DRV: next_rdata = o_drive_type[0];
      `MMRB_OFF_B_DRV: next_rdata = o_drive_type[1];
      `MMRB_OFF_C_DRV: next_rdata = o_drive_type[2];
      `MMRB_OFF_D_DRV: next_rdata = o_drive_type[3];
      `MMRB_OFF_A_ICELL: next_rdata = i_input_cells[0];
      `MMRB_OFF_B_ICELL: next_rdata = i_input_cells[1];
      `MMRB_OFF_C_ICELL: next_rdata = i_input_cells[2];
      // enables as they reach the pin drivers
      `MMRB_OFF_A_OE: next_rdata = o_pin_oe[0];
      `MMRB_OFF_B_OE: next_rdata = o_pin_oe[1];
      `MMRB_OFF_C_OE: next_rdata = o_pin_oe[2];
      `MMRB_OFF_D_OE: next_rdata = o_pin_oe[3];
      `MMRB_OFF_CELL_AB: next_rdata = o_output_cells[7:0];
      `MMRB_OFF_CELL_BC: next_rdata = o_output_cells[15:8];
      `MMRB_OFF_MASK_AB: next_rdata = mask_ab;
      `MMRB_OFF_MASK_BC: next_rdata = mask_bc;
      `MMRB_OFF_PWR0: next_rdata = o_power_0;
      `MMRB_OFF_PWR2: next_rdata = o_power_2;
      // lock status straight from the protection bits
      `MMRB_OFF_PRI_LOCK: next_rdata = {4'h0, i_primary_lock};
      `MMRB_OFF_SEC_LOCK:
        next_rdata = {i_security, 5'h00, i_secondary_lock};
      `MMRB_OFF_PAGE: next_rdata = o_page;
      `MMRB_OFF_PLACE: next_rdata = place;
      default: next_rdata = `MMRB_RST_BYTE;
    endcase
  end

  // Read data holds until the next read of the window
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rdata <= `MMRB_RST_BYTE;
    else if (i_rd && in_win)
      o_rdata <= next_rdata;
  end

  // selects from the decode array, gated by space placement
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_mem_sel <= '0;
    else
    begin
      // primary and secondary enabled per space; SRAM always enabled in data space, by its bit in program space
      o_mem_sel.primary <= i_decode_sel.primary & {4{i_psen
        ? place[`MMRB_PLACE_PRI_PROG] : place[`MMRB_PLACE_PRI_DATA]}};
      o_mem_sel.secondary <= i_decode_sel.secondary & {2{i_psen
        ? place[`MMRB_PLACE_SEC_PROG] : place[`MMRB_PLACE_SEC_DATA]}};
      o_mem_sel.sram <= i_decode_sel.sram
        && (!i_psen || place[`MMRB_PLACE_SRAM_PROG]);
    end
  end

  // four primary sectors, two secondary sectors
  assign flash_target = i_flash_req.target == mmrb_pkg::BLK_PRIMARY
    || i_flash_req.target == mmrb_pkg::BLK_SECONDARY;
  // a locked or absent sector refuses the cycle
  assign locked = i_flash_req.target == mmrb_pkg::BLK_PRIMARY
    ? i_primary_lock[i_flash_req.sector]
    : (i_flash_req.sector[1] || i_secondary_lock[i_flash_req.sector[0]]);

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    accept = 1'b0;
    next_refused = 1'b0;
    unique case (state)
      mmrb_pkg::FL_IDLE:
      begin
        if (i_flash_req.start)
        begin
          // core path is limited to the flash arrays
          if (flash_target)
            accept = !locked;
          else
            accept = i_flash_req.path != mmrb_pkg::PATH_CORE;
          next_refused = !accept;
          if (accept)
          begin
            next_state = mmrb_pkg::FL_BUSY;
            next_cnt = i_flash_req.erase ? ERASE_CNT : PROG_CNT;
          end
        end
      end
      mmrb_pkg::FL_BUSY:
      begin
        next_refused = i_flash_req.start;
        // suspend only applies to an erase in progress
        if (i_flash_req.suspend && erasing)
          next_state = mmrb_pkg::FL_SUSP;
        else if (cnt <= 16'h0001)
          next_state = mmrb_pkg::FL_IDLE;
        else
          next_cnt = cnt - 16'h0001;
      end
      mmrb_pkg::FL_SUSP:
      begin
        next_refused = i_flash_req.start;
        if (i_flash_req.resume)
          next_state = mmrb_pkg::FL_BUSY;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= mmrb_pkg::FL_IDLE;
      cnt <= 16'h0000;
      erasing <= 1'b0;
      o_busy <= 1'b0;
      o_erase_suspended <= 1'b0;
      o_refused <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      if (accept)
        erasing <= i_flash_req.erase;
      o_busy <= next_state == mmrb_pkg::FL_BUSY;
      o_erase_suspended <= next_state == mmrb_pkg::FL_SUSP;
      o_refused <= next_refused;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  a_window_ignore: assert property (
    i_wr && !in_win |=> $stable(o_page))
    else $error("write outside window changed page");
  a_pin_read: assert property (
    i_rd && in_win && offset == `MMRB_OFF_A_IN
    |=> o_rdata == $past(i_pin_in[0]))
    else $error("pin input read wrong");
  a_out_drive: assert property (
    wr_hit && offset == `MMRB_OFF_D_OUT
    ##1 !(wr_hit && offset == `MMRB_OFF_D_OUT)
    |=> o_pin_out[3] == $past(i_wdata, 2))
    else $error("output value not driven");
  a_mask_keeps: assert property (
    wr_hit && offset == `MMRB_OFF_CELL_AB
    |=> (o_output_cells[7:0] & $past(mask_ab))
      == ($past(o_output_cells[7:0]) & $past(mask_ab)))
    else $error("masked cell changed");
  a_lock_refuse: assert property (
    state == mmrb_pkg::FL_IDLE && i_flash_req.start && flash_target
    && locked |=> o_refused && !o_busy)
    else $error("locked sector accepted");
  a_core_logic: assert property (
    state == mmrb_pkg::FL_IDLE && i_flash_req.start && !flash_target
    && i_flash_req.path == mmrb_pkg::PATH_CORE |=> o_refused)
    else $error("core changed logic array");
  a_suspend_erase: assert property (
    state == mmrb_pkg::FL_BUSY && !erasing |=> !o_erase_suspended)
    else $error("program cycle suspended");
  a_busy_pin: assert property (
    i_rdy_busy_en |=> o_pin_out[2][3] == !o_busy && o_pin_oe[2][3])
    else $error("ready busy pin wrong");
  a_unmapped_zero: assert property (
    i_rd && in_win && offset == 8'hff |=> o_rdata == 8'h00)
    else $error("unassigned offset not zero");

  c_program: cover property (
    state == mmrb_pkg::FL_IDLE ##1 state == mmrb_pkg::FL_BUSY);
  c_suspend: cover property (
    o_erase_suspended ##[1:20] o_busy);
  c_masked: cover property (
    wr_hit && offset == `MMRB_OFF_CELL_BC && mask_bc != 8'h00);
  c_refused: cover property (o_refused);
endmodule // mmrb_top

// ===== verification/mmrb_core_model.sv
// Core side of the internal bus: byte reads and writes, address latch.
// Assumes i_ref_clk is the block clock; drives 1 ns after rising edges.
`timescale 1ns/1ns
module mmrb_core_model (
  input wire logic i_ref_clk,
  input wire logic [7:0] i_rdata,
  output logic [15:0] o_addr,
  output logic o_ale,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_wdata
);
  initial
  begin
    o_addr = 16'h0000;
    o_ale = 1'b0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end
  // Released lines invert so stale values never look valid
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_rd = 1'b0;
    o_addr = ~a;
    @(posedge i_ref_clk);
    #1;
    d = i_rdata;
  endtask
  // One address phase with no strobe, as when fetching code elsewhere
  task automatic addr_phase(input logic [15:0] a);
    @(posedge i_ref_clk);
    #1;
    o_addr = a;
    o_ale = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_ale = 1'b0;
    o_addr = ~a;
  endtask
endmodule // mmrb_core_model

// ===== verification/mmrb_top_tb.sv
// Self-checking bench for the memory module register bank.
// Assumes mmrb_core_model plays the core; flash requests come from here.
`timescale 1ns/1ns
module mmrb_top_tb;
  localparam int PC = 4;
  localparam int EC = 8;
  localparam logic [15:0] W = 16'h7c00;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] base = 8'h7c;
  logic psen = 1'b0;
  logic rb_en = 1'b1;
  logic sec = 1'b1;
  logic [3:0] plock = 4'b0010;
  logic [1:0] slock = 2'b01;
  logic [3:0][7:0] pin_in = 32'h3c5a96e1;
  logic [2:0][7:0] icell = 24'h1248ad;
  mmrb_pkg::mmrb_mem_sel_t dsel = '0;
  mmrb_pkg::mmrb_flash_req_t freq = '0;
  logic [15:0] addr;
  logic ale, rd, wr, busy, susp, refused;
  logic [7:0] wdata, rdata, pw0, pw2, page;
  logic [3:0][7:0] pout, poe, drv;
  logic [15:0] cells;
  mmrb_pkg::mmrb_mem_sel_t msel;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  mmrb_top #(.PROGRAM_CYCLES(PC), .ERASE_CYCLES(EC)) mmrb_top_inst (
    .i_ref_clk(clk), .i_arst_n(arst_n), .i_window_base(base),
    .i_addr(addr), .i_ale(ale), .i_rd(rd), .i_wr(wr), .i_wdata(wdata),
    .i_pin_in(pin_in), .i_input_cells(icell), .i_primary_lock(plock),
    .i_secondary_lock(slock), .i_security(sec), .i_rdy_busy_en(rb_en),
    .i_psen(psen), .i_decode_sel(dsel), .i_flash_req(freq),
    .o_rdata(rdata), .o_pin_out(pout), .o_pin_oe(poe),
    .o_drive_type(drv), .o_output_cells(cells), .o_power_0(pw0),
    .o_power_2(pw2), .o_page(page), .o_mem_sel(msel), .o_busy(busy),
    .o_erase_suspended(susp), .o_refused(refused));
  mmrb_core_model mmrb_core_model_inst (
    .i_ref_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_ale(ale),
    .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_fail = n_fail + 1;
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr8(input logic [7:0] off, input logic [7:0] d);
    mmrb_core_model_inst.bus_wr(W | {8'h00, off}, d);
  endtask
  task automatic rchk(input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] d;
    mmrb_core_model_inst.bus_rd(W | {8'h00, off}, d);
    chk(d, exp);
  endtask
  // v = {erase, target, sector, path}; reports refusal and busy count
  task automatic fl(input logic [6:0] v, output logic r, output int nb,
                    output int np);
    @(posedge clk);
    #1;
    // Whole request in one assignment so no half-built value is seen
    freq = mmrb_pkg::mmrb_flash_req_t'({1'b1, v, 2'b00});
    step(1);
    freq.start = 1'b0;
    r = refused;
    nb = 0;
    np = 0;
    repeat (EC + 6)
    begin
      nb = nb + int'(busy);
      np = np + int'(!pout[2][3]);
      step(1);
      r = r | refused;
    end
  endtask
  task automatic t_reset;
    rchk(8'h02, 8'h00);
    rchk(8'he2, 8'h00);
    chk(pout[2][3], 1'b1);
    chk(poe[2][3], 1'b1);
  endtask
  task automatic t_regs;
    logic [7:0] rw [25] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h09, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h20,
      8'h21, 8'h22, 8'h23, 8'hb0, 8'hb4, 8'he0, 8'he2, 8'h04, 8'h06,
      8'h08};
    foreach (rw[i]) wr8(rw[i], rw[i] ^ 8'ha5);
    foreach (rw[i]) rchk(rw[i], rw[i] ^ 8'ha5);
    chk(pw0, 8'h15);
    chk(pw2, 8'h11);
    chk(page, 8'h45);
    chk(drv[3], 8'hb2);
  endtask
  task automatic t_window;
    mmrb_core_model_inst.bus_wr(16'h7d04, 8'h11);
    rchk(8'h04, 8'ha1);
    wr8(8'h00, 8'h77);
    rchk(8'h00, 8'he1);
    rchk(8'h11, 8'h3c);
    rchk(8'h18, 8'h12);
    wr8(8'hc0, 8'hff);
    rchk(8'hc0, 8'h02);
    rchk(8'hc2, 8'h81);
    wr8(8'h30, 8'h5a);
    rchk(8'h30, 8'h00);
  endtask
  task automatic t_pins;
    wr8(8'h02, 8'h00);
    wr8(8'h08, 8'h00);
    wr8(8'h06, 8'hff);
    wr8(8'h04, 8'ha5);
    step(2);
    chk(pout[0], 8'ha5);
    rchk(8'h0c, 8'hff);
    wr8(8'h08, 8'h0f);
    step(2);
    chk(poe[0], 8'hfa);
    wr8(8'h08, 8'h00);
    wr8(8'h06, 8'h0f);
    step(2);
    rchk(8'h0c, 8'h0f);
    wr8(8'h02, 8'hff);
    wr8(8'h03, 8'hff);
    mmrb_core_model_inst.addr_phase(16'h3c77);
    step(2);
    chk({pout[1], pout[0], poe[0]}, 24'h3c77ff);
  endtask
  task automatic t_cells;
    wr8(8'h22, 8'h00);
    wr8(8'h20, 8'h3c);
    wr8(8'h22, 8'h0f);
    wr8(8'h20, 8'hc3);
    step(1);
    chk(cells[7:0], 8'hcc);
    rchk(8'h20, 8'hcc);
    wr8(8'h23, 8'hf0);
    wr8(8'h21, 8'hff);
    rchk(8'h21, 8'h8f);
  endtask
  task automatic t_flash;
    logic [6:0] bad [5] = '{7'b0000100, 7'b0010000, 7'b0011000,
      7'b0100000, 7'b0110000};
    logic [6:0] ok [3] = '{7'b0100001, 7'b0110010, 7'b1010100};
    logic r;
    int nb, np;
    // routines run from the other array, so only requests appear here
    fl(7'b0000000, r, nb, np);
    chk({r, 8'(nb), 8'(np)}, {1'b0, 8'(PC), 8'(PC)});
    foreach (bad[i])
    begin
      fl(bad[i], r, nb, np);
      chk({r, 8'(nb)}, 9'h100);
    end
    foreach (ok[i])
    begin
      fl(ok[i], r, nb, np);
      chk({r, 8'(nb)}, {1'b0, 8'(ok[i][6] ? EC : PC)});
    end
    rb_en = 1'b0;
    wr8(8'h12, 8'h08);
    fl(7'b0000000, r, nb, np);
    chk({8'(np), 8'(nb)}, {8'h00, 8'(PC)});
    rb_en = 1'b1;
    freq = mmrb_pkg::mmrb_flash_req_t'({1'b1, 7'b1001100, 2'b00});
    step(1);
    freq = '0;
    step(2);
    freq.suspend = 1'b1;
    step(1);
    freq.suspend = 1'b0;
    step(1);
    chk({busy, susp, pout[2][3]}, 3'b011);
    freq.start = 1'b1;
    step(1);
    freq.start = 1'b0;
    r = refused;
    step(1);
    chk(r | refused, 1'b1);
    freq.resume = 1'b1;
    step(1);
    freq.resume = 1'b0;
    nb = 0;
    repeat (EC + 4)
    begin
      nb = nb + int'(busy);
      step(1);
    end
    chk({susp, busy, 1'(nb > 0 && nb < EC)}, 3'b001);
  endtask
  task automatic t_sel;
    dsel = mmrb_pkg::mmrb_mem_sel_t'(7'h53);
    wr8(8'he2, 8'h1f);
    step(2);
    chk(msel, 7'h53);
    psen = 1'b1;
    step(2);
    chk(msel, 7'h53);
    wr8(8'he2, 8'h00);
    step(2);
    chk(msel, 7'h00);
    psen = 1'b0;
    step(2);
    chk(msel, 7'h01);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    arst_n = 1'b1;
    step(2);
    t_reset();
    t_regs();
    t_window();
    t_pins();
    t_cells();
    t_flash();
    t_sel();
    tally_and_finish();
  end
endmodule // mmrb_top_tb
